// ---- core/port_a_gpio_data.sv ----
// Port A eight-pin data register with Wishbone access
//
// Notes on behaviour
// - An eight-bit read/write data register holds one bit per pin, bit n for pin n.
// - In output or other-function mode a read returns the stored bit, not the pin.
// - In output mode a written bit is stored and driven on the pin.
// - With the upper mode bit set a read returns the pin's sampled level.
// - In other-function and input modes a write only updates the stored bit.
// - Each pin has a pull-up on in mode 1,0 and off in mode 1,1.
// - Mode 0,0 hands the pin to its multiplexed peripheral function.
`timescale 1ns/1ps
module port_a_gpio_data
  import port_a_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] pin_mode_upper_bit_i,
  input wire logic [7:0] pin_mode_lower_bit_i,
  input wire logic [7:0] pin_level_i,
  output logic [7:0] pin_out_o,
  output logic [7:0] pin_oe_o,
  output logic [7:0] pullup_en_o,
  input wire logic [7:0] alt_out_i,
  input wire logic [7:0] alt_oe_i,
  output logic [7:0] alt_in_o
);
  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  logic [7:0] port_a_data_reg_q;
  logic [7:0] port_a_data_reg_d;
  logic [31:0] rdata_q;
  logic [7:0] read_bits;
  wire take;
  wire hit = (wb_adr_i == PORT_A_DATA_OFFSET);
  wire wr_en = take && wb_we_i && hit && wb_sel_i[0];
  wire [31:0] rdata_d = hit ? {24'h000000, read_bits} : UNMAPPED_READ;

  wb_regslave u_bus (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cyc_i(wb_cyc_i),
    .stb_i(wb_stb_i),
    .ack_o(wb_ack_o),
    .take_o(take)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Data register
  assign port_a_data_reg_d = wr_en ? wb_dat_i[7:0] : port_a_data_reg_q;
  assign wb_dat_o = rdata_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_a_data_reg_q <= PORT_A_DATA_RESET;
      rdata_q <= UNMAPPED_READ;
    end else begin
      port_a_data_reg_q <= port_a_data_reg_d;
      rdata_q <= take ? rdata_d : UNMAPPED_READ;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins
  genvar n;
  generate
    for (n = 0; n < PIN_COUNT; n++) begin : g_pin
      pin_cell u_cell (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .mode_i({pin_mode_upper_bit_i[n], pin_mode_lower_bit_i[n]}),
        .data_bit_i(port_a_data_reg_d[n]),
        .pin_level_i(pin_level_i[n]),
        .alt_out_i(alt_out_i[n]),
        .alt_oe_i(alt_oe_i[n]),
        .read_bit_o(read_bits[n]),
        .pin_out_o(pin_out_o[n]),
        .pin_oe_o(pin_oe_o[n]),
        .pullup_en_o(pullup_en_o[n]),
        .alt_in_o(alt_in_o[n])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_RESET_CLEAR: assert property (@(posedge clk_i)
    rst_i |=> port_a_data_reg_q == 8'h00)
    else $error("data not cleared by reset");
  AST_WRITE_STORE: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_en |=> port_a_data_reg_q == $past(wb_dat_i[7:0]))
    else $error("write not stored");
  AST_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    !wr_en |=> $stable(port_a_data_reg_q))
    else $error("data changed without write");
  AST_READ_INPUT: assert property (@(posedge clk_i) disable iff (rst_i)
    take && !wb_we_i && hit |=> wb_ack_o &&
    wb_dat_o[7:0] == (($past(pin_mode_upper_bit_i) & $past(pin_level_i)) |
    (~$past(pin_mode_upper_bit_i) & $past(port_a_data_reg_q))))
    else $error("read data wrong for mode");
  AST_DRIVE_OUT: assert property (@(posedge clk_i) disable iff (rst_i)
    (~pin_mode_upper_bit_i[0] & pin_mode_lower_bit_i[0]) ##1 !$past(rst_i)
    |-> pin_oe_o[0] && pin_out_o[0] == port_a_data_reg_q[0])
    else $error("output mode pin not driven with data");
  AST_ALT_PASS: assert property (@(posedge clk_i) disable iff (rst_i)
    !pin_mode_upper_bit_i[1] && !pin_mode_lower_bit_i[1] ##1 !$past(rst_i)
    |-> pin_oe_o[1] == $past(alt_oe_i[1]) && pin_out_o[1] == $past(alt_out_i[1]))
    else $error("other function not passed to pin");
  AST_ACK_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_UPPER_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("upper read bits not zero");
endmodule : port_a_gpio_data

// ---- core/port_a_pkg.sv ----
// Constants shared by the port A data block
package port_a_pkg;
  localparam int unsigned PIN_COUNT = 8;
  localparam logic [3:0] PORT_A_DATA_OFFSET = 4'h0;
  localparam logic [7:0] PORT_A_DATA_RESET = 8'h00;
  localparam logic [1:0] MODE_OTHER = 2'h0;
  localparam logic [1:0] MODE_OUTPUT = 2'h1;
  localparam logic [1:0] MODE_IN_PULLUP = 2'h2;
  localparam logic [1:0] MODE_IN_NOPULL = 2'h3;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } bus_state_e;
endpackage : port_a_pkg

// ---- core/pin_cell.sv ----
// One port pin: mode decode, drive, pull-up and read selection
`timescale 1ns/1ps
module pin_cell
  import port_a_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [1:0] mode_i,
  input wire logic data_bit_i,
  input wire logic pin_level_i,
  input wire logic alt_out_i,
  input wire logic alt_oe_i,
  output logic read_bit_o,
  output logic pin_out_o,
  output logic pin_oe_o,
  output logic pullup_en_o,
  output logic alt_in_o
);
  wire is_output = (mode_i == MODE_OUTPUT);
  wire is_other = (mode_i == MODE_OTHER);
  wire is_input = mode_i[1];
  wire out_d = is_other ? alt_out_i : data_bit_i;
  wire oe_d = is_other ? alt_oe_i : is_output;
  wire pull_d = (mode_i == MODE_IN_PULLUP);

  // Pin level is synchronous to clk_i; read select is combinational
  assign read_bit_o = is_input ? pin_level_i : data_bit_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_out_o <= 1'b0;
      pin_oe_o <= 1'b0;
      pullup_en_o <= 1'b0;
      alt_in_o <= 1'b0;
    end else begin
      pin_out_o <= out_d;
      pin_oe_o <= oe_d;
      pullup_en_o <= pull_d;
      alt_in_o <= pin_level_i;
    end
  end

  AST_PULLUP: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 !$past(rst_i) |-> pullup_en_o == ($past(mode_i) == MODE_IN_PULLUP))
    else $error("pull-up does not follow mode");
  AST_NODRIVE_IN: assert property (@(posedge clk_i) disable iff (rst_i)
    is_input ##1 !$past(rst_i) |-> !pin_oe_o)
    else $error("pin driven in input mode");
endmodule : pin_cell

// ---- core/wb_regslave.sv ----
// Classic Wishbone slave handshake with one-cycle ack
`timescale 1ns/1ps
module wb_regslave
  import port_a_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  output logic take_o
);
  bus_state_e state_q;
  bus_state_e state_d;

  // Take once per request, then ack and drop for a cycle
  assign take_o = (state_q == BUS_IDLE) && cyc_i && stb_i;
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      BUS_IDLE: if (take_o) state_d = BUS_ACK;
      BUS_ACK: state_d = BUS_IDLE;
      default: state_d = BUS_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= BUS_IDLE;
      ack_o <= 1'b0;
    end else begin
      state_q <= state_d;
      ack_o <= take_o;
    end
  end
endmodule : wb_regslave

// ---- verif/board_pins.sv ----
// Board side of the eight port pins
`timescale 1ns/1ps
module board_pins (
  input wire logic clk_i,
  input wire logic [7:0] pin_out_i,
  input wire logic [7:0] pin_oe_i,
  input wire logic [7:0] pullup_en_i,
  input wire logic [7:0] ext_val_i,
  input wire logic [7:0] ext_en_i,
  output logic [7:0] level_o
);
  // Undriven pins without pull-up wander
  logic [7:0] float_q = 8'h55;
  always @(posedge clk_i) begin
    float_q <= ~float_q;
  end
  assign level_o = (pin_oe_i & pin_out_i)
    | (~pin_oe_i & ext_en_i & ext_val_i)
    | (~pin_oe_i & ~ext_en_i & (pullup_en_i | float_q));
endmodule : board_pins

// ---- verif/port_a_gpio_data_bench.sv ----
// Self-checking bench for the port A data register
`timescale 1ns/1ps
module port_a_gpio_data_bench;
  import port_a_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack;
  logic [3:0] adr = 4'h0, sel = 4'h1;
  logic [31:0] wdat = 32'h0, rdat, rd;
  logic [7:0] mu = 8'h00, ml = 8'h00, lvl, pout, poe, pue, ain;
  logic [7:0] aout = 8'h00, aoe = 8'h00, ev = 8'h00, ee = 8'h00;
  int n_mismatch = 0, checks = 0;
  always #2 clk_i = ~clk_i;
  port_a_gpio_data u_port_a_gpio_data (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .pin_mode_upper_bit_i(mu), .pin_mode_lower_bit_i(ml),
    .pin_level_i(lvl), .pin_out_o(pout), .pin_oe_o(poe), .pullup_en_o(pue),
    .alt_out_i(aout), .alt_oe_i(aoe), .alt_in_o(ain));
  board_pins u_board_pins (.clk_i(clk_i), .pin_out_i(pout), .pin_oe_i(poe),
    .pullup_en_i(pue), .ext_val_i(ev), .ext_en_i(ee), .level_o(lvl));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : bus
  task automatic setm(input logic [7:0] u, input logic [7:0] l, input logic [7:0] v,
                      input logic [7:0] e);
    @(posedge clk_i);
    mu <= u;
    ml <= l;
    ev <= v;
    ee <= e;
    repeat (3) @(posedge clk_i);
  endtask : setm
  task automatic wrap_up();
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(0, 4'h0, 8'h00);
    chk(rd, 32'h0);
    chk({pue, poe}, 16'h0);
    $display("reset test done");
    setm(8'h00, 8'hff, 8'h00, 8'h00);
    bus(1, 4'h0, 8'ha5);
    bus(0, 4'h0, 8'h00);
    chk(rd, 32'ha5);
    chk({poe, pout}, 16'hffa5);
    $display("output test done");
    setm(8'hff, 8'hff, 8'h3c, 8'hff);
    bus(0, 4'h0, 8'h00);
    chk(rd, 32'h3c);
    bus(1, 4'h0, 8'h0f);
    chk({poe, pue}, 16'h0);
    setm(8'h00, 8'hff, 8'h00, 8'h00);
    bus(0, 4'h0, 8'h00);
    chk(rd, 32'h0f);
    $display("input test done");
    setm(8'hff, 8'h00, 8'h00, 8'h00);
    chk(pue, 8'hff);
    bus(0, 4'h0, 8'h00);
    chk(rd, 32'hff);
    $display("pull-up test done");
    @(posedge clk_i);
    aout <= 8'h96;
    aoe <= 8'hff;
    setm(8'h00, 8'h00, 8'h00, 8'h00);
    chk({ain, pout}, 16'h9696);
    bus(0, 4'h0, 8'h00);
    chk(rd, 32'h0f);
    $display("other function test done");
    setm(8'hf0, 8'hcc, 8'h40, 8'hc0);
    bus(0, 4'h0, 8'h00);
    chk(rd, 32'h7f);
    bus(1, 4'h3, 8'h55);
    bus(0, 4'h3, 8'h00);
    chk(rd, 32'h0);
    @(posedge clk_i);
    sel <= 4'h0;
    bus(1, 4'h0, 8'h50);
    @(posedge clk_i);
    sel <= 4'h1;
    bus(0, 4'h0, 8'h00);
    chk(rd, 32'h7f);
    $display("mixed and refused test done");
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(0, 4'h0, 8'h00);
    chk(rd, 32'h70);
    $display("mid-run reset test done");
    wrap_up();
  end
  initial begin
    repeat (2000) @(posedge clk_i);
    n_mismatch++;
    wrap_up();
  end
endmodule : port_a_gpio_data_bench
